// File: ctb_timer.v
// Purpose : three 16-bit down counters with control word, byte access,
//           cascading, and a pacer that steps conversions through channels
// Assumes : host strobes are one clock wide and synchronous to clock
// Notes   : counting is binary; the decimal flag is stored only
//
// How it works
// - counter 2 ticks from an internal 1 MHz stroke, never a pin
// - cascade selects feed one counter's output into the previous counter's clock
// - control word 30 hex picks counter 0, mode 0, binary, two bytes
// - outside modes 1 and 5, counting happens only while the gate is high
// - full count loaded with gate low; decrements only while gate high
// - one-shot: gate rise starts cycle, output low; re-rise reloads
// - one-shot: gate falling mid-cycle does not stop counting
// - one-shot: output high at zero until next gate rise; load once
// - each trigger starts one conversion, channels step start to end
// - start equal to end converts that one channel every time
// - control word: select 7:6, access 5:4, mode 3:1, decimal bit 0
// - access bits zero latch the current count for later reads
// - two-byte access uses low/high pairs via a byte-order toggle
// - the conversion trigger responds to rising edges
`include "ctb_defs.vh"

module ctb_timer #(
    parameter INT_DIV = `CTB_INT_DIV
) (
    input  wire        clock,
    input  wire        rst_b,
    input  wire        io_wr,
    input  wire        io_rd,
    input  wire [1:0]  io_addr,
    input  wire [7:0]  io_wdata,
    output wire [7:0]  io_rdata,
    input  wire        ext_clk0,
    input  wire        ext_clk1,
    input  wire [2:0]  gate_pin,
    input  wire        cascade0,
    input  wire        cascade1,
    output wire [2:0]  cnt_out,
    input  wire        adc_trig_pin,
    input  wire [2:0]  scan_start,
    input  wire [2:0]  scan_end,
    input  wire        scan_restart,
    output wire        conv_start,
    output wire [2:0]  conv_chan
);

// ----------------------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------------------
    reg  [2:0]  gate_s1_q;
    reg  [2:0]  gate_s2_q;
    reg  [1:0]  eclk_s1_q;
    reg  [1:0]  eclk_s2_q;
    reg         trig_s1_q;
    reg         trig_s2_q;
    reg         trig_prev_q;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gate_s1_q <= 3'h0;
            gate_s2_q <= 3'h0;
            eclk_s1_q <= 2'h0;
            eclk_s2_q <= 2'h0;
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
        end else begin
            gate_s1_q <= gate_pin;
            gate_s2_q <= gate_s1_q;
            eclk_s1_q <= {ext_clk1, ext_clk0};
            eclk_s2_q <= eclk_s1_q;
            trig_s1_q <= adc_trig_pin;
            trig_s2_q <= trig_s1_q;
        end
    end

// ----------------------------------------------------------------------------
// internal 1 MHz stroke for counter 2
// ----------------------------------------------------------------------------
    reg  [7:0]  div_q;
    reg         int_tick_q;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_q      <= 8'h00;
            int_tick_q <= 1'b0;
        end else if (div_q == INT_DIV[7:0] - 8'h01) begin
            div_q      <= 8'h00;
            int_tick_q <= 1'b1;
        end else begin
            div_q      <= div_q + 8'h01;
            int_tick_q <= 1'b0;
        end
    end

// ----------------------------------------------------------------------------
// counters
// ----------------------------------------------------------------------------
    wire [2:0]  out_w;
    wire [23:0] rbyte_w;
    wire [2:0]  src_w;

    // counter 2 has no clock pin at all, so it cannot count outside events
    assign src_w[0] = cascade0 ? out_w[1] : eclk_s2_q[0];
    assign src_w[1] = cascade1 ? out_w[2] : eclk_s2_q[1];
    assign src_w[2] = int_tick_q;

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_cnt
            reg  [2:0]  mode_q;
            reg         bcd_q;
            reg  [1:0]  acc_q;
            reg  [15:0] init_q;
            reg  [15:0] cnt_q;
            reg  [15:0] lat_q;
            reg         lat_v_q;
            reg         wtog_q;
            reg         rtog_q;
            reg  [7:0]  lowb_q;
            reg         loaded_q;
            reg         pend_q;
            reg         run_q;
            reg         trig_q;
            reg         gprev_q;
            reg         sprev_q;
            reg         out_q;

            wire        ctl_hit = io_wr && (io_addr == `CTB_OFS_CTRL)
                                  && (io_wdata[`CTB_SEL_HI:`CTB_SEL_LO] == i);
            wire        wr_hit  = io_wr && (io_addr == i);
            wire        rd_hit  = io_rd && (io_addr == i);
            wire        gate    = gate_s2_q[i];
            wire        tick    = src_w[i] & ~sprev_q;
            wire [15:0] view    = lat_v_q ? lat_q : cnt_q;
            wire        use_hi  = (acc_q == `CTB_ACC_MSB)
                                  || ((acc_q == `CTB_ACC_BOTH) && rtog_q);
            // odd counts: high half gets (n+1)/2 strokes, low half (n-1)/2
            wire [15:0] sq_hi   = (init_q + {15'h0000, init_q[0]}) & 16'hFFFE;
            wire [15:0] sq_lo   = (init_q - {15'h0000, init_q[0]}) & 16'hFFFE;
            // modes 6 and 7 fold onto 2 and 3: the top mode bit is ignored once bit 2 is set
            wire [2:0]  wmode   = io_wdata[2] ? {1'b0, io_wdata[2:1]}
                                              : io_wdata[3:1];

            assign out_w[i]           = out_q;
            assign rbyte_w[i*8 +: 8]  = use_hi ? view[15:8] : view[7:0];

            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    mode_q   <= `CTB_RST_MODE;
                    bcd_q    <= 1'b0;
                    acc_q    <= `CTB_RST_ACC;
                    init_q   <= `CTB_RST_COUNT;
                    cnt_q    <= `CTB_RST_COUNT;
                    lat_q    <= `CTB_RST_COUNT;
                    lat_v_q  <= 1'b0;
                    wtog_q   <= 1'b0;
                    rtog_q   <= 1'b0;
                    lowb_q   <= `CTB_RST_BYTE;
                    loaded_q <= 1'b0;
                    pend_q   <= 1'b0;
                    run_q    <= 1'b0;
                    trig_q   <= 1'b0;
                    gprev_q  <= 1'b0;
                    sprev_q  <= 1'b0;
                    out_q    <= 1'b1;
                end else begin
                    sprev_q <= src_w[i];
                    gprev_q <= gate;
                    // ---- counting on each stroke of the counter's clock ----
                    if (tick && loaded_q) begin
                        case (mode_q)
                        3'h0: begin
                            if (pend_q) begin
                                cnt_q  <= init_q;
                                pend_q <= 1'b0;
                            end else if (gate) begin
                                cnt_q <= cnt_q - 16'h0001;
                                if (cnt_q == 16'h0001)
                                    out_q <= 1'b1;
                            end
                        end
                        3'h1, 3'h5: begin
                            if (mode_q == 3'h5 && !out_q)
                                out_q <= 1'b1;
                            if (trig_q) begin
                                cnt_q  <= init_q;
                                run_q  <= 1'b1;
                                trig_q <= 1'b0;
                                if (mode_q == 3'h1)
                                    out_q <= 1'b0;
                            end else if (run_q) begin
                                // gate level not consulted while running
                                cnt_q <= cnt_q - 16'h0001;
                                if (cnt_q == 16'h0001) begin
                                    run_q <= 1'b0;
                                    out_q <= (mode_q == 3'h1);
                                end
                            end
                        end
                        3'h2: begin
                            if (pend_q || trig_q) begin
                                cnt_q  <= init_q;
                                pend_q <= 1'b0;
                                trig_q <= 1'b0;
                                out_q  <= 1'b1;
                            end else if (gate) begin
                                if (cnt_q == 16'h0001) begin
                                    cnt_q <= init_q;
                                    out_q <= 1'b1;
                                end else begin
                                    cnt_q <= cnt_q - 16'h0001;
                                    out_q <= (cnt_q != 16'h0002);
                                end
                            end else begin
                                out_q <= 1'b1;
                            end
                        end
                        3'h3: begin
                            if (pend_q || trig_q) begin
                                cnt_q  <= sq_hi;
                                pend_q <= 1'b0;
                                trig_q <= 1'b0;
                                out_q  <= 1'b1;
                            end else if (gate) begin
                                if (cnt_q <= 16'h0002) begin
                                    out_q <= ~out_q;
                                    cnt_q <= out_q ? sq_lo : sq_hi;
                                end else begin
                                    cnt_q <= cnt_q - 16'h0002;
                                end
                            end else begin
                                out_q <= 1'b1;
                            end
                        end
                        default: begin
                            if (pend_q) begin
                                cnt_q  <= init_q;
                                pend_q <= 1'b0;
                                run_q  <= 1'b1;
                                out_q  <= 1'b1;
                            end else if (run_q && gate) begin
                                cnt_q <= cnt_q - 16'h0001;
                                if (cnt_q == 16'h0001) begin
                                    run_q <= 1'b0;
                                    out_q <= 1'b0;
                                end
                            end else begin
                                out_q <= 1'b1;
                            end
                        end
                        endcase
                    end
                    // a gate rise is caught on the fast clock so none is lost
                    if (gate && !gprev_q)
                        trig_q <= 1'b1;
                    // ---- host reads ----
                    if (rd_hit) begin
                        if (acc_q == `CTB_ACC_BOTH)
                            rtog_q <= ~rtog_q;
                        if (acc_q != `CTB_ACC_BOTH || rtog_q)
                            lat_v_q <= 1'b0;
                    end
                    // ---- host count writes ----
                    if (wr_hit) begin
                        if (acc_q == `CTB_ACC_BOTH && !wtog_q) begin
                            lowb_q <= io_wdata;
                            wtog_q <= 1'b1;
                        end else begin
                            wtog_q   <= 1'b0;
                            init_q   <= (acc_q == `CTB_ACC_LSB) ? {8'h00, io_wdata}
                                      : (acc_q == `CTB_ACC_MSB) ? {io_wdata, 8'h00}
                                      : {io_wdata, lowb_q};
                            loaded_q <= 1'b1;
                            pend_q   <= 1'b1;
                            if (mode_q == 3'h0)
                                out_q <= 1'b0;
                        end
                    end
                    // ---- control word ----
                    if (ctl_hit) begin
                        if (io_wdata[`CTB_ACC_HI:`CTB_ACC_LO] == `CTB_ACC_LATCH) begin
                            if (!lat_v_q) begin
                                lat_q   <= cnt_q;
                                lat_v_q <= 1'b1;
                            end
                        end else begin
                            acc_q    <= io_wdata[`CTB_ACC_HI:`CTB_ACC_LO];
                            mode_q   <= wmode;
                            bcd_q    <= io_wdata[`CTB_BCD_BIT];
                            wtog_q   <= 1'b0;
                            rtog_q   <= 1'b0;
                            lat_v_q  <= 1'b0;
                            loaded_q <= 1'b0;
                            pend_q   <= 1'b0;
                            run_q    <= 1'b0;
                            trig_q   <= 1'b0;
                            out_q    <= (wmode != 3'h0);
                        end
                    end
                end
            end
        end
    endgenerate

    assign cnt_out = out_w;

// ----------------------------------------------------------------------------
// read data and conversion pacer
// ----------------------------------------------------------------------------
    reg  [7:0]  rdata_q;
    reg  [2:0]  next_q;
    reg  [2:0]  chan_q;
    reg         start_q;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q     <= `CTB_RST_BYTE;
            trig_prev_q <= 1'b0;
            next_q      <= `CTB_RST_CHAN;
            chan_q      <= `CTB_RST_CHAN;
            start_q     <= 1'b0;
        end else begin
            trig_prev_q <= trig_s2_q;
            if (io_rd)
                rdata_q <= (io_addr == `CTB_OFS_CTRL) ? `CTB_RST_BYTE
                                                      : rbyte_w[io_addr*8 +: 8];
            start_q <= trig_s2_q && !trig_prev_q;
            if (trig_s2_q && !trig_prev_q) begin
                chan_q <= next_q;
                next_q <= (next_q == scan_end) ? scan_start
                                               : next_q + 3'h1;
            end else if (scan_restart) begin
                next_q <= scan_start;
            end
        end
    end

    assign io_rdata   = rdata_q;
    assign conv_start = start_q;
    assign conv_chan  = chan_q;

endmodule

// File: ctb_defs.vh
// Purpose : constants for the three-counter timer and the conversion pacer
// Assumes : 100 MHz system clock
// Notes   : definitions only
`ifndef CTB_DEFS_VH
`define CTB_DEFS_VH

// ----------------------------------------------------------------------------
// host port offsets
// ----------------------------------------------------------------------------
`define CTB_OFS_CNT0       2'h0
`define CTB_OFS_CNT1       2'h1
`define CTB_OFS_CNT2       2'h2
`define CTB_OFS_CTRL       2'h3

// ----------------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------------
`define CTB_SEL_HI         7
`define CTB_SEL_LO         6
`define CTB_ACC_HI         5
`define CTB_ACC_LO         4
`define CTB_MODE_HI        3
`define CTB_MODE_LO        1
`define CTB_BCD_BIT        0
`define CTB_SEL_READBACK   2'h3
`define CTB_ACC_LATCH      2'h0
`define CTB_ACC_LSB        2'h1
`define CTB_ACC_MSB        2'h2
`define CTB_ACC_BOTH       2'h3
`define CTB_CTRL_EVENT_CNT 8'h30

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CTB_RST_BYTE       8'h00
`define CTB_RST_COUNT      16'h0000
`define CTB_RST_MODE       3'h0
`define CTB_RST_ACC        2'h3
`define CTB_RST_CHAN       3'h0

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CTB_SYS_HZ         100000000
`define CTB_INT_CLK_HZ     1000000
`define CTB_INT_DIV        (`CTB_SYS_HZ / `CTB_INT_CLK_HZ)

`endif

// File: ctb_timer_checker.sv
// Purpose : port-level assertions for the three-counter timer
// Assumes : one clock domain, reset asynchronous and active low
// Notes   : bound into every ctb_timer instance
module ctb_timer_checker #(
    parameter INT_DIV = 100
) (
    input wire       clock,
    input wire       rst_b,
    input wire       io_wr,
    input wire       io_rd,
    input wire [1:0] io_addr,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata,
    input wire       ext_clk0,
    input wire       ext_clk1,
    input wire [2:0] gate_pin,
    input wire       cascade0,
    input wire       cascade1,
    input wire [2:0] cnt_out,
    input wire       adc_trig_pin,
    input wire [2:0] scan_start,
    input wire [2:0] scan_end,
    input wire       scan_restart,
    input wire       conv_start,
    input wire [2:0] conv_chan
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    chk_reset_outputs: assert property (disable iff (1'b0)
        !rst_b |-> cnt_out == 3'h7 && !conv_start && conv_chan == 3'h0)
        else $error("outputs not at reset values");
    chk_trig_to_conv: assert property ($rose(adc_trig_pin) |-> ##3 conv_start)
        else $error("trigger edge gave no conversion");
    chk_conv_cause: assert property (conv_start |->
        $past(adc_trig_pin, 3) && !$past(adc_trig_pin, 4))
        else $error("conversion without trigger edge");
    chk_conv_pulse: assert property (conv_start |=> !conv_start)
        else $error("conversion start wider than one cycle");
    chk_chan_stable: assert property (!conv_start |-> $stable(conv_chan))
        else $error("channel moved without conversion");
    chk_chan_wrap: assert property (conv_start && $past(conv_chan) == scan_end
        && scan_start < scan_end |-> conv_chan == scan_start)
        else $error("scan did not wrap to start");
    chk_single_chan: assert property (conv_start && scan_start == scan_end
        && $past(conv_chan) == scan_start |-> conv_chan == scan_start)
        else $error("single channel scan moved");
    chk_ctrl_read_zero: assert property (io_rd && io_addr == 2'h3 |=> io_rdata == 8'h00)
        else $error("control port read not zero");
    chk_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data changed without read");
    chk_ctrl_out_low: assert property (io_wr && io_addr == 2'h3 && io_wdata == 8'h30
        |-> ##[1:2] !cnt_out[0])
        else $error("counter 0 output not low after mode 0 setup");
    cover property (conv_start && scan_start == scan_end);
    cover property (io_rd && io_addr == 2'h0);
    cover property ($rose(cnt_out[1]));
endmodule

bind ctb_timer ctb_timer_checker #(.INT_DIV(INT_DIV)) chk_u (
    .clock(clock), .rst_b(rst_b), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .ext_clk0(ext_clk0), .ext_clk1(ext_clk1),
    .gate_pin(gate_pin), .cascade0(cascade0), .cascade1(cascade1), .cnt_out(cnt_out),
    .adc_trig_pin(adc_trig_pin), .scan_start(scan_start), .scan_end(scan_end),
    .scan_restart(scan_restart), .conv_start(conv_start), .conv_chan(conv_chan));

// File: ctb_host_model.sv
// Purpose : host side of the timer byte port
// Assumes : strobes launched at the falling edge, one cycle wide
// Notes   : two-byte transfers always go low byte then high byte
module ctb_host_model (
    input  wire logic       clock,
    input  wire logic [7:0] io_rdata,
    output logic            io_wr,
    output logic            io_rd,
    output logic [1:0]      io_addr,
    output logic [7:0]      io_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_addr  = 2'h0;
        io_wdata = 8'h00;
    end
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(negedge clock);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge clock);
        io_wr    = 1'b0;
        // released data is scrambled so no stale byte can be mistaken for live
        io_wdata = ~d;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(negedge clock);
        io_addr = a;
        io_rd   = 1'b1;
        @(negedge clock);
        io_rd   = 1'b0;
        @(negedge clock);
        d       = io_rdata;
    endtask
    task automatic wr16(input logic [1:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a, v[15:8]);
    endtask
    task automatic rd16(input logic [1:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a, v[15:8]);
    endtask
endmodule

// File: testbench.sv
// Purpose : self-checking bench for the three-counter timer and pacer
// Assumes : internal divider shortened to 4 system cycles
// Notes   : counter 2 output is wired to the trigger pin for pacing
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4;
    logic       clock = 1'b0;
    logic       rst_b = 1'b1;
    logic [1:0] ext_clk = 2'h0;
    logic [2:0] gate_pin = 3'h0;
    logic       cascade0 = 1'b0;
    logic       cascade1 = 1'b0;
    logic [2:0] scan_start = 3'h0;
    logic [2:0] scan_end = 3'h0;
    logic       scan_restart = 1'b0;
    logic       trig_sel = 1'b0;
    int         num_errors = 0;
    int         compares = 0;
    wire        io_wr, io_rd, conv_start;
    wire  [1:0] io_addr;
    wire  [7:0] io_wdata, io_rdata;
    wire  [2:0] cnt_out, conv_chan;
    wire        adc_trig_pin = trig_sel & cnt_out[2];
    always #5 clock = ~clock;
    ctb_host_model host_u (.clock(clock), .io_rdata(io_rdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata));
    ctb_timer #(.INT_DIV(DIV)) dut_u (.clock(clock), .rst_b(rst_b), .io_wr(io_wr),
        .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .ext_clk0(ext_clk[0]), .ext_clk1(ext_clk[1]), .gate_pin(gate_pin),
        .cascade0(cascade0), .cascade1(cascade1), .cnt_out(cnt_out),
        .adc_trig_pin(adc_trig_pin), .scan_start(scan_start), .scan_end(scan_end),
        .scan_restart(scan_restart), .conv_start(conv_start), .conv_chan(conv_chan));
    task automatic results();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask
    // index 3 waits on the conversion pulse, others on a counter output
    task automatic wait_lvl(input int k, input logic v, output int n);
        n = 0;
        while (((k == 3) ? conv_start : cnt_out[k]) !== v && n < 300) begin
            @(negedge clock);
            n++;
        end
        if (n >= 300) begin
            num_errors++;
            $display("BAD %0t: wait timed out", $time);
            results();
        end
    endtask
    task automatic per(input int k, output int n);
        int a;
        repeat (2) wait_lvl(k, 1'b0, a);
        wait_lvl(k, 1'b1, a);
        wait_lvl(k, 1'b0, a);
        wait_lvl(k, 1'b1, n);
        n = n + a;
    endtask
    // strokes reach the counter three cycles after the pin, so both phases last three
    task automatic pulse(input int k);
        @(negedge clock);
        ext_clk[k] = 1'b1;
        idle(3);
        ext_clk[k] = 1'b0;
        idle(3);
    endtask
    task automatic rise1();
        gate_pin[1] = 1'b0;
        idle(4);
        gate_pin[1] = 1'b1;
        idle(4);
    endtask
    initial begin
        int          k;
        int          n;
        logic [15:0] v;
        logic [2:0]  s, e, x;
        k = $urandom(32'h4973914B);
        // a real falling edge, so the asynchronous reset acts before the first clock
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        cmp(cnt_out, 3'h7);
        cmp(conv_chan, 3'h0);
        $display("test reset done");
        gate_pin = 3'h7;
        idle(4);
        host_u.wr(2'h3, 8'h30);
        host_u.wr16(2'h0, 16'hFFFF);
        k = $urandom_range(9, 2);
        repeat (k) pulse(0);
        host_u.wr(2'h3, 8'h00);
        host_u.rd16(2'h0, v);
        cmp(v, 65535 - k + 1);
        gate_pin[0] = 1'b0;
        idle(4);
        repeat (3) pulse(0);
        host_u.wr(2'h3, 8'h00);
        host_u.rd16(2'h0, v);
        cmp(v, 65535 - k + 1);
        host_u.rd(2'h3, v[7:0]);
        cmp(v[7:0], 8'h00);
        $display("test events done");
        gate_pin[1] = 1'b0;
        host_u.wr(2'h3, 8'h72);
        host_u.wr16(2'h1, 16'h0004);
        rise1();
        pulse(1);
        cmp(cnt_out[1], 1'b0);
        gate_pin[1] = 1'b0;
        repeat (2) pulse(1);
        rise1();
        repeat (4) pulse(1);
        cmp(cnt_out[1], 1'b0);
        pulse(1);
        cmp(cnt_out[1], 1'b1);
        repeat (2) pulse(1);
        cmp(cnt_out[1], 1'b1);
        rise1();
        pulse(1);
        gate_pin[1] = 1'b0;
        repeat (3) pulse(1);
        cmp(cnt_out[1], 1'b0);
        pulse(1);
        cmp(cnt_out[1], 1'b1);
        host_u.wr(2'h3, 8'h7A);
        host_u.wr16(2'h1, 16'h0002);
        rise1();
        repeat (2) pulse(1);
        cmp(cnt_out[1], 1'b1);
        pulse(1);
        cmp(cnt_out[1], 1'b0);
        pulse(1);
        cmp(cnt_out[1], 1'b1);
        $display("test one-shot done");
        gate_pin = 3'h7;
        host_u.wr(2'h3, 8'hB6);
        host_u.wr16(2'h2, 16'h0004);
        per(2, n);
        cmp(n, 4 * DIV);
        cascade1 = 1'b1;
        host_u.wr(2'h3, 8'h76);
        host_u.wr16(2'h1, 16'h0002);
        fork
            per(1, n);
            repeat (20) pulse(1);
        join
        cmp(n, 8 * DIV);
        cascade0 = 1'b1;
        host_u.wr(2'h3, 8'h36);
        host_u.wr16(2'h0, 16'h0002);
        per(0, n);
        cmp(n, 16 * DIV);
        host_u.wr(2'h3, 8'hB4);
        host_u.wr16(2'h2, 16'h0004);
        per(2, n);
        cmp(n, 4 * DIV);
        $display("test cascade done");
        for (int r = 0; r < 2; r++) begin
            trig_sel = 1'b0;
            idle(8);
            s = 3'($urandom_range(3, 0));
            e = (r == 0) ? 3'($urandom_range(7, s + 1)) : s;
            scan_start = s;
            scan_end = e;
            scan_restart = 1'b1;
            @(negedge clock);
            scan_restart = 1'b0;
            trig_sel = 1'b1;
            x = s;
            repeat (10) begin
                wait_lvl(3, 1'b0, n);
                wait_lvl(3, 1'b1, n);
                cmp(conv_chan, x);
                x = (x == e) ? s : x + 3'h1;
            end
            $display("test pacer done");
        end
        results();
    end
endmodule
